// File: src/touch_key_pkg.sv
// Shared constants and types for the touch key PWM output block.
// Assumes one 20 MHz clock and sensor levels from a front end on that clock.
package touch_key_pkg;

  localparam int unsigned KEY_COUNT   = 6;
  localparam int unsigned LEVEL_W     = 10;
  localparam int unsigned THRESH_W    = 8;

  // Clock and timing, each figure in its own unit
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned TONE_HZ     = 4_000;
  localparam int unsigned BURST_MS    = 80;
  localparam int unsigned TONE_HALF_CYCLES = CLK_HZ / (2 * TONE_HZ);
  localparam int unsigned BURST_CYCLES     = (CLK_HZ / 1000) * BURST_MS;
  localparam int unsigned BURST_W     = 21;
  localparam int unsigned TONE_W      = 12;

  // Period counter: counts 0 .. PWM_TOP, then restarts
  localparam int unsigned PWM_W       = 16;
  localparam logic [15:0] PWM_TOP     = 16'h0022;

  // Compare values: output high while count is below these
  localparam logic [15:0] DUTY_POWER  = 16'h0013;
  localparam logic [15:0] DUTY_MENU   = 16'h0018;
  localparam logic [15:0] DUTY_PROG_UP = 16'h000C;
  localparam logic [15:0] DUTY_PROG_DN = 16'h001B;
  localparam logic [15:0] DUTY_VOL_UP = 16'h0011;
  localparam logic [15:0] DUTY_VOL_DN = 16'h001E;
  localparam logic [15:0] DUTY_TV_AV  = 16'h0009;

  // Key positions in the touched vector
  localparam int unsigned KEY_POWER   = 0;
  localparam int unsigned KEY_MENU    = 1;
  localparam int unsigned KEY_PROG_UP = 2;
  localparam int unsigned KEY_PROG_DN = 3;
  localparam int unsigned KEY_VOL_UP  = 4;
  localparam int unsigned KEY_VOL_DN  = 5;

  localparam logic [9:0]  LEVEL_RESET = 10'h000;

  typedef struct packed {
    logic                              valid;
    logic [KEY_COUNT-1:0][LEVEL_W-1:0] level;
  } sense_sample_t;

endpackage

// File: src/touch_sensor_detect.sv
// One sensor channel: reference capture and threshold comparison.
// Assumes sample_valid and level come from logic on the same clock.
`timescale 1ns/1ps
module touch_sensor_detect
  import touch_key_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                sample_valid,
  input  wire logic [LEVEL_W-1:0]  level,
  input  wire logic [THRESH_W-1:0] touch_detect_threshold,
  output logic                     touched,
  output logic                     ref_valid
);

  logic [LEVEL_W-1:0] ref_level;
  logic [LEVEL_W:0]   limit;

  assign limit = {1'b0, ref_level} + {{(LEVEL_W+1-THRESH_W){1'b0}}, touch_detect_threshold};

  // First sample after reset becomes the untouched reference
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_level <= LEVEL_RESET;
      ref_valid <= 1'b0;
    end else if (sample_valid && !ref_valid) begin
      ref_level <= level;
      ref_valid <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      touched <= 1'b0;
    end else if (sample_valid && ref_valid) begin
      touched <= ({1'b0, level} > limit);
    end
  end

  chk_ref_capture: assert property (
    @(posedge clk) disable iff (!arst_n)
    sample_valid && !ref_valid |=> ref_valid && ref_level == $past(level))
    else $error("reference not captured from first sample");

  chk_touch_decide: assert property (
    @(posedge clk) disable iff (!arst_n)
    sample_valid && ref_valid |=>
      touched == ({1'b0, $past(level)} > ({1'b0, $past(ref_level)}
                 + {3'b000, $past(touch_detect_threshold)})))
    else $error("touch decision does not match threshold");

endmodule

// File: src/touch_key_pwm_output.sv
// Touch key PWM output: key code as PWM duty, buzzer burst on touch.
// Assumes sensor samples arrive on clk from a measurement front end.
//
// Notes on behaviour
// - A touch when no key was touched before drives the buzzer with a 50% 4kHz square wave for 80ms, then idle low.
// - With no key touched the analog-level output stays high.
// - With a key touched the analog-level output toggles as PWM at that key's own duty.
// - The period counter runs from the system clock with no prescaler, period 35 counts.
// - The period counter is 16 bits, single slope, and restarts from zero after its top value.
// - A sensor is touched when its level exceeds its reference by more than the threshold.
// - The first valid sample of each sensor after reset becomes its reference, touched or not.
// - Six independent keys, each with its own detection and its own output code.
// - Duties are power 54.38%, menu 68.58%, up 34.25%, down 77.16%, vol+ 48.56%, vol- 85.72%.
// - Program up and down together give the TV/AV code at 25.69% duty.
`timescale 1ns/1ps
module touch_key_pwm_output
  import touch_key_pkg::*;
#(
  parameter int unsigned BURST_LEN = BURST_CYCLES
) (
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire sense_sample_t       sample,
  input  wire logic [THRESH_W-1:0] touch_detect_threshold,
  output logic                     analog_level_out,
  output logic                     buzzer_out,
  output logic [KEY_COUNT-1:0]     key_touched,
  output logic                     calibrated
);

  logic [KEY_COUNT-1:0] touched;
  logic [KEY_COUNT-1:0] ref_ok;
  logic [PWM_W-1:0]     pwm_period_counter;
  logic [PWM_W-1:0]     duty;
  logic                 any_touch;
  logic                 any_touch_prev;
  logic                 start;
  logic [BURST_W-1:0]   burst_left;
  logic [TONE_W-1:0]    tone_cnt;

  // One detector per key
  for (genvar k = 0; k < KEY_COUNT; k++) begin : g_key
    touch_sensor_detect u_det (
      .clk                    (clk),
      .arst_n                 (arst_n),
      .sample_valid           (sample.valid),
      .level                  (sample.level[k]),
      .touch_detect_threshold (touch_detect_threshold),
      .touched                (touched[k]),
      .ref_valid              (ref_ok[k])
    );
  end

  assign any_touch = |touched;
  assign start     = any_touch && !any_touch_prev;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      key_touched <= '0;
      calibrated  <= 1'b0;
    end else begin
      key_touched <= touched;
      calibrated  <= &ref_ok;
    end
  end

  // Key to duty; the pair code wins over single keys, then lowest index
  always_comb begin
    duty = PWM_TOP;
    if (touched[KEY_PROG_UP] && touched[KEY_PROG_DN]) begin
      duty = DUTY_TV_AV;
    end else if (touched[KEY_POWER]) begin
      duty = DUTY_POWER;
    end else if (touched[KEY_MENU]) begin
      duty = DUTY_MENU;
    end else if (touched[KEY_PROG_UP]) begin
      duty = DUTY_PROG_UP;
    end else if (touched[KEY_PROG_DN]) begin
      duty = DUTY_PROG_DN;
    end else if (touched[KEY_VOL_UP]) begin
      duty = DUTY_VOL_UP;
    end else if (touched[KEY_VOL_DN]) begin
      duty = DUTY_VOL_DN;
    end
  end

  // Single-slope period counter on every clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwm_period_counter <= '0;
    end else if (pwm_period_counter == PWM_TOP) begin
      pwm_period_counter <= '0;
    end else begin
      pwm_period_counter <= pwm_period_counter + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      analog_level_out <= 1'b1;
    end else if (!any_touch) begin
      analog_level_out <= 1'b1;
    end else begin
      analog_level_out <= (pwm_period_counter < duty);
    end
  end

  // Buzzer burst: restarts when a key is touched after none was, idle low afterwards
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      any_touch_prev <= 1'b0;
    end else begin
      any_touch_prev <= any_touch;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      burst_left <= '0;
      tone_cnt   <= '0;
      buzzer_out <= 1'b0;
    end else if (start) begin
      burst_left <= BURST_W'(BURST_LEN - 1);
      tone_cnt   <= TONE_W'(TONE_HALF_CYCLES - 1);
      buzzer_out <= 1'b1;
    end else if (burst_left != '0) begin
      burst_left <= burst_left - 1'b1;
      if (burst_left == BURST_W'(1)) begin
        buzzer_out <= 1'b0;
      end else if (tone_cnt == '0) begin
        tone_cnt   <= TONE_W'(TONE_HALF_CYCLES - 1);
        buzzer_out <= !buzzer_out;
      end else begin
        tone_cnt <= tone_cnt - 1'b1;
      end
    end else begin
      buzzer_out <= 1'b0;
    end
  end

  sequence held_touch;
    any_touch ##1 any_touch;
  endsequence

  sequence burst_begin;
    start ##1 (buzzer_out && burst_left == BURST_W'(BURST_LEN - 1));
  endsequence

  chk_pwm_wrap: assert property (
    @(posedge clk) disable iff (!arst_n)
    pwm_period_counter == PWM_TOP |=> pwm_period_counter == '0)
    else $error("period counter did not restart after top");

  chk_pwm_step: assert property (
    @(posedge clk) disable iff (!arst_n)
    pwm_period_counter != PWM_TOP |=>
      pwm_period_counter == $past(pwm_period_counter) + 16'h0001)
    else $error("period counter did not advance by one");

  chk_idle_high: assert property (
    @(posedge clk) disable iff (!arst_n)
    !any_touch |=> analog_level_out)
    else $error("analog output not high while idle");

  chk_duty_level: assert property (
    @(posedge clk) disable iff (!arst_n)
    any_touch |=> analog_level_out == ($past(pwm_period_counter) < $past(duty)))
    else $error("analog output does not follow duty compare");

  chk_tvav_code: assert property (
    @(posedge clk) disable iff (!arst_n)
    touched[KEY_PROG_UP] && touched[KEY_PROG_DN] |-> duty == DUTY_TV_AV)
    else $error("pair of program keys not mapped to TV/AV code");

  chk_power_code: assert property (
    @(posedge clk) disable iff (!arst_n)
    touched == 6'b00_0001 |-> duty == DUTY_POWER)
    else $error("power key not mapped to its duty");

  chk_menu_code: assert property (
    @(posedge clk) disable iff (!arst_n)
    touched == 6'b00_0010 |-> duty == DUTY_MENU)
    else $error("menu key not mapped to its duty");

  chk_up_code: assert property (
    @(posedge clk) disable iff (!arst_n)
    touched == 6'b00_0100 |-> duty == DUTY_PROG_UP)
    else $error("program up key not mapped to its duty");

  chk_down_code: assert property (
    @(posedge clk) disable iff (!arst_n)
    touched == 6'b00_1000 |-> duty == DUTY_PROG_DN)
    else $error("program down key not mapped to its duty");

  chk_volup_code: assert property (
    @(posedge clk) disable iff (!arst_n)
    touched == 6'b01_0000 |-> duty == DUTY_VOL_UP)
    else $error("volume up key not mapped to its duty");

  chk_voldn_code: assert property (
    @(posedge clk) disable iff (!arst_n)
    touched == 6'b10_0000 |-> duty == DUTY_VOL_DN)
    else $error("volume down key not mapped to its duty");

  chk_burst_start: assert property (
    @(posedge clk) disable iff (!arst_n)
    start |-> burst_begin)
    else $error("buzzer burst did not start on touch");

  chk_tone_hold: assert property (
    @(posedge clk) disable iff (!arst_n)
    burst_left > BURST_W'(1) && tone_cnt != '0 && !start |=> $stable(buzzer_out))
    else $error("buzzer toggled before half period ended");

  chk_buzz_quiet: assert property (
    @(posedge clk) disable iff (!arst_n)
    burst_left <= BURST_W'(1) && !start |=> !buzzer_out)
    else $error("buzzer active outside a burst");

  chk_no_retrigger: assert property (
    @(posedge clk) disable iff (!arst_n)
    held_touch ##0 (burst_left == '0) |=> !buzzer_out)
    else $error("burst retriggered while key held");

endmodule

// File: testbench/host_level_reader.sv
// Host model: reads the filtered level as high cycles per PWM period.
// Assumes the period counter wraps every PWM_TOP+1 clock cycles.
`timescale 1ns/1ps
module host_level_reader
  import touch_key_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       analog_level_out,
  output logic [7:0]      high_count
);
  logic [7:0] phase;
  logic [7:0] acc;
  // Any window of one whole period sees the exact duty, whatever its phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase      <= 8'h00;
      acc        <= 8'h00;
      high_count <= 8'h00;
    end else if (phase == PWM_TOP[7:0]) begin
      phase      <= 8'h00;
      acc        <= 8'h00;
      high_count <= acc + {7'h00, analog_level_out};
    end else begin
      phase <= phase + 8'h01;
      acc   <= acc + {7'h00, analog_level_out};
    end
  end
endmodule

// File: testbench/touch_key_pwm_output_tb.sv
// Self-checking bench for the touch key PWM output block.
// Assumes a shortened buzzer burst and the host model on the analog output.
`timescale 1ns/1ps
module touch_key_pwm_output_tb;
  import touch_key_pkg::*;
  localparam int unsigned BLEN = 10000;
  localparam logic [9:0]  BASE = 10'h064;
  logic                clk;
  logic                arst_n;
  sense_sample_t       sample;
  logic [THRESH_W-1:0] thr;
  logic                analog_level_out;
  logic                buzzer_out;
  logic [KEY_COUNT-1:0] key_touched;
  logic                calibrated;
  logic [7:0]          high_count;
  int                  err_count = 0;
  int                  n_tests = 0;
  int                  cycles = 0;

  touch_key_pwm_output #(.BURST_LEN(BLEN)) dut (
    .clk(clk), .arst_n(arst_n), .sample(sample), .touch_detect_threshold(thr),
    .analog_level_out(analog_level_out), .buzzer_out(buzzer_out),
    .key_touched(key_touched), .calibrated(calibrated));

  host_level_reader host (
    .clk(clk), .arst_n(arst_n), .analog_level_out(analog_level_out),
    .high_count(high_count));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One valid sample; pressed keys sit lift above the base level
  task automatic send(input logic [5:0] press, input logic [9:0] lift);
    @(posedge clk);
    sample.valid <= 1'b1;
    for (int k = 0; k < 6; k++) sample.level[k] <= BASE + (press[k] ? lift : 10'h000);
    @(posedge clk);
    sample.valid <= 1'b0;
    repeat (80) @(posedge clk);
  endtask

  task automatic calibrate;
    send(6'h00, 10'h000);
    chk("calibrated", 16'h0001, {15'h0, calibrated});
    chk("idle high count", 16'h0023, {8'h0, high_count});
  endtask

  task automatic key_duties;
    logic [15:0] duty [6];
    duty = '{DUTY_POWER, DUTY_MENU, DUTY_PROG_UP, DUTY_PROG_DN, DUTY_VOL_UP, DUTY_VOL_DN};
    for (int k = 0; k < 6; k++) begin
      send(6'h01 << k, {2'b00, thr} + 10'h001);
      chk("key_touched", 16'h0001 << k, {10'h0, key_touched});
      chk("key duty", duty[k], {8'h0, high_count});
      send(6'h00, 10'h000);
      chk("release", 16'h0023, {8'h0, high_count});
    end
  endtask

  task automatic boundary_and_pair;
    send(6'h01, {2'b00, thr});
    chk("at threshold", 16'h0000, {10'h0, key_touched});
    send(6'h0C, {2'b00, thr} + 10'h001);
    chk("pair touched", 16'h000C, {10'h0, key_touched});
    chk("tv av duty", DUTY_TV_AV, {8'h0, high_count});
    send(6'h00, 10'h000);
  endtask

  task automatic buzzer_burst;
    int highs;
    int rises;
    logic prev;
    highs = 0;
    rises = 0;
    prev = 1'b0;
    repeat (12000) @(posedge clk);
    @(posedge clk);
    sample.valid <= 1'b1;
    sample.level[4] <= BASE + {2'b00, thr} + 10'h001;
    @(posedge clk);
    sample.valid <= 1'b0;
    repeat (11000) begin
      @(negedge clk);
      if (buzzer_out === 1'b1) highs++;
      if (buzzer_out === 1'b1 && prev === 1'b0) rises++;
      prev = buzzer_out;
    end
    chk("burst high cycles", 16'(BLEN / 2), 16'(highs));
    chk("burst tone periods", 16'(BLEN / (2 * TONE_HALF_CYCLES)), 16'(rises));
    send(6'h10, {2'b00, thr} + 10'h001);
    chk("held no retrigger", 16'h0000, {15'h0, buzzer_out});
    send(6'h00, 10'h000);
    send(6'h10, {2'b00, thr} + 10'h001);
    chk("new touch burst", 16'h0001, {15'h0, buzzer_out});
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      summarize();
    end
  end

  initial begin
    arst_n = 1'b0;
    sample = '0;
    thr = 8'h06;
    repeat (5) @(posedge clk);
    chk("reset outputs", 16'h0008, {12'h0, analog_level_out, buzzer_out, calibrated,
        |key_touched});
    @(posedge clk);
    arst_n <= 1'b1;
    calibrate();
    key_duties();
    boundary_and_pair();
    buzzer_burst();
    summarize();
  end
endmodule
